/* File: rtl/scss_pkg.sv */
// Constants, register map and carrier types for the switching clock block
package scss_pkg;
   // ==========================================================
   // Clock rates and timing
   localparam int CLK_KHZ = 200000;
   localparam int LF_KHZ = 100;
   localparam int LF_DIV_CYC = CLK_KHZ / LF_KHZ;
   localparam int SS_MOD_KHZ = 24;
   localparam int SS_PERIOD_CYC = CLK_KHZ / SS_MOD_KHZ;
   localparam int HF_DIV = 8;
   localparam int HF_NOM_MHZ = 20;
   localparam int HALF_NUM = CLK_KHZ / 1000 * HF_DIV / 2;
   localparam int HALF_NOM_CYC = HALF_NUM / HF_NOM_MHZ;
   localparam int SS_NARROW_PCT = 5;
   localparam int SS_WIDE_PCT = 10;
   localparam int SS_NARROW_DEV = HALF_NOM_CYC * SS_NARROW_PCT / 100;
   localparam int SS_WIDE_DEV = HALF_NOM_CYC * SS_WIDE_PCT / 100;
   localparam int SS_NARROW_STEP_CYC = SS_PERIOD_CYC / (4 * SS_NARROW_DEV);
   localparam int SS_WIDE_STEP_CYC = SS_PERIOD_CYC / (4 * SS_WIDE_DEV);
   // ==========================================================
   // Sync input bands
   localparam int B0_FMIN_KHZ = 2000;
   localparam int B0_FMAX_KHZ = 3000;
   localparam int B1_FMIN_KHZ = 333;
   localparam int B1_FMAX_KHZ = 500;
   localparam int B0_PMIN = (CLK_KHZ + B0_FMAX_KHZ - 1) / B0_FMAX_KHZ;
   localparam int B0_PMAX = CLK_KHZ / B0_FMIN_KHZ;
   localparam int B1_PMIN = (CLK_KHZ + B1_FMAX_KHZ - 1) / B1_FMAX_KHZ;
   localparam int B1_PMAX = CLK_KHZ / B1_FMIN_KHZ;
   localparam int PLL_MULT_B0 = 1;
   localparam int PLL_MULT_B1 = 6;
   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_EVENT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   localparam int CTRL_SPREAD_EN_BIT = 0;
   localparam int CTRL_WIDTH_BIT = 1;
   localparam int CTRL_SYNC_EN_BIT = 2;
   localparam int CTRL_BAND_BIT = 3;
   localparam int CTRL_OUT_EN_BIT = 4;
   localparam int CTRL_TUNE_LSB = 8;
   localparam int EVENT_FAULT_BIT = 0;
   localparam int MASK_FAULT_BIT = 0;
   localparam logic [3:0] TUNE_RST = 4'h0;
   localparam logic MASK_RST = 1'b0;
   // ==========================================================
   // Types
   typedef struct packed {
      logic [3:0] tune;
      logic out_en;
      logic band;
      logic sync_en;
      logic width;
      logic spread_en;
   } scss_ctrl_t;
   typedef struct packed {
      logic pll_on;
      logic spread_on;
      logic ext_used;
      logic fault_live;
   } scss_status_t;
   typedef enum {SRC_INT, SRC_EXT} scss_src_t;
endpackage : scss_pkg

/* File: rtl/scss_top.sv */
// Switching clock generator with spread spectrum, sync input check and sync output
// Summary of operation
// - Spread spectrum runs when spread enable is 1, stops at 0
// - Spread enable loads its one-time-programmed default at power-up
// - Width select limits deviation to 5 percent at 0, 10 percent at 1
// - Width select loads its one-time-programmed default at power-up
// - Internal spread modulates at 24 kHz
// - External sync enabled with PLL on suppresses spreading regardless of spread enable
// - Sync default 0 keeps PLL off, internal clock always used
// - Sync default 1 keeps PLL on, reference internal or sync input
// - Band select 0 accepts only 2000 to 3000 kHz
// - Band select 1 accepts only 333 to 500 kHz
// - Sync frequency outside the chosen band is invalid
// - Band select loads its one-time-programmed default at power-up
// - Missing or invalid clock: fall back internal, set event, pull interrupt low
// - Live fault bit is 1 while input absent or invalid, else 0
// - Return to external only when event cleared and input valid
// - Sync output held low when disabled, toggles at switching frequency when enabled
// - Sync output enable loads its one-time-programmed default
// - Host may change sync output enable; output stays 2.0 to 3.0 MHz
// - Internal switching frequency is high-frequency clock divided by eight
// - Manual tuning ignored while spreading or external sync
// - Return to external is decided on a 100 kHz tick; fallback acts at once
`timescale 1ns/1ps
module scss_top (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_sync_input,
   input wire logic otp_spread_enable_default,
   input wire logic otp_spread_width_default,
   input wire logic otp_ext_sync_enable_default,
   input wire logic otp_sync_band_default,
   input wire logic otp_sync_output_default,
   output logic sw_clk_out,
   output logic sync_output,
   output logic pll_enable,
   output logic ext_source_active,
   output logic spread_active,
   output logic irq_out_n
);
   // ==========================================================
   // Reset and strap capture
   logic [1:0] rst_q;
   logic rst_n;
   logic [4:0] otp_s1_q, otp_s2_q;
   logic [1:0] init_q;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         otp_s1_q <= 5'h00;
         otp_s2_q <= 5'h00;
         init_q <= 2'h0;
      end else begin
         otp_s1_q <= {otp_sync_output_default, otp_sync_band_default, otp_ext_sync_enable_default,
                      otp_spread_width_default, otp_spread_enable_default};
         otp_s2_q <= otp_s1_q;
         if (init_q != 2'h3) begin
            init_q <= init_q + 2'h1;
         end
      end
   end
   wire load_otp = (init_q == 2'h2);

   // ==========================================================
   // Functions
   function automatic logic in_band(input logic [9:0] p, input logic band);
      if (band) begin
         in_band = (p >= 10'(scss_pkg::B1_PMIN)) && (p <= 10'(scss_pkg::B1_PMAX));
      end else begin
         in_band = (p >= 10'(scss_pkg::B0_PMIN)) && (p <= 10'(scss_pkg::B0_PMAX));
      end
   endfunction : in_band

   function automatic logic [9:0] tune_half(input logic [3:0] code);
      unique case (code)
         4'h1: tune_half = 10'(scss_pkg::HALF_NUM / 21);
         4'h2: tune_half = 10'(scss_pkg::HALF_NUM / 22);
         4'h3: tune_half = 10'(scss_pkg::HALF_NUM / 23);
         4'h4: tune_half = 10'(scss_pkg::HALF_NUM / 24);
         4'h9: tune_half = 10'(scss_pkg::HALF_NUM / 16);
         4'ha: tune_half = 10'(scss_pkg::HALF_NUM / 17);
         4'hb: tune_half = 10'(scss_pkg::HALF_NUM / 18);
         4'hc: tune_half = 10'(scss_pkg::HALF_NUM / 19);
         default: tune_half = 10'(scss_pkg::HALF_NOM_CYC);
      endcase
   endfunction : tune_half

   // ==========================================================
   // Registers and APB slave
   scss_pkg::scss_ctrl_t ctrl_q;
   scss_pkg::scss_status_t stat;
   logic pll_on_q, event_q, mask_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   wire access = psel & penable & ~pready_q;
   wire take = psel & penable & pready_q;
   wire wr = take & pwrite;
   wire hit_ctrl = (paddr == scss_pkg::ADDR_CTRL);
   wire hit_stat = (paddr == scss_pkg::ADDR_STATUS);
   wire hit_evt = (paddr == scss_pkg::ADDR_EVENT);
   wire hit_mask = (paddr == scss_pkg::ADDR_MASK);
   wire mapped = hit_ctrl | hit_stat | hit_evt | hit_mask;
   wire evt_clr = wr & hit_evt & pwdata[scss_pkg::EVENT_FAULT_BIT];
   wire [31:0] rd_word = hit_ctrl ? {20'h00000, ctrl_q.tune, 3'h0, ctrl_q[4:0]} :
                         hit_stat ? {28'h0000000, stat} :
                         hit_evt ? {31'h00000000, event_q} :
                         hit_mask ? {31'h00000000, mask_q} : 32'h00000000;
   wire [4:0] ctrl_wbits = {pwdata[scss_pkg::CTRL_OUT_EN_BIT], pwdata[scss_pkg::CTRL_BAND_BIT],
                            pwdata[scss_pkg::CTRL_SYNC_EN_BIT], pwdata[scss_pkg::CTRL_WIDTH_BIT],
                            pwdata[scss_pkg::CTRL_SPREAD_EN_BIT]};

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= access;
         pslverr_q <= access & ~mapped;
         if (access) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_word;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= '{tune: scss_pkg::TUNE_RST, default: 1'b0};
         pll_on_q <= 1'b0;
         mask_q <= scss_pkg::MASK_RST;
      end else if (load_otp) begin
         ctrl_q.spread_en <= otp_s2_q[0];
         ctrl_q.width <= otp_s2_q[1];
         ctrl_q.sync_en <= otp_s2_q[2];
         pll_on_q <= otp_s2_q[2];
         ctrl_q.band <= otp_s2_q[3];
         ctrl_q.out_en <= otp_s2_q[4];
      end else if (wr && hit_ctrl) begin
         ctrl_q <= {pwdata[scss_pkg::CTRL_TUNE_LSB +: 4], ctrl_wbits};
      end else if (wr && hit_mask) begin
         mask_q <= pwdata[scss_pkg::MASK_FAULT_BIT];
      end
   end

   // ==========================================================
   // Low frequency control tick
   logic [10:0] lf_cnt_q;
   logic lf_tick_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lf_cnt_q <= 11'h000;
         lf_tick_q <= 1'b0;
      end else begin
         lf_tick_q <= (lf_cnt_q == 11'(scss_pkg::LF_DIV_CYC - 1));
         lf_cnt_q <= (lf_cnt_q == 11'(scss_pkg::LF_DIV_CYC - 1)) ? 11'h000 : lf_cnt_q + 11'h001;
      end
   end

   // ==========================================================
   // Sync input measurement
   logic ext_s1_q, ext_s2_q, ext_s3_q;
   logic [9:0] per_q, meas_q;
   logic fault_live_q;
   wire rise = ext_s2_q & ~ext_s3_q;
   wire [9:0] pmax = ctrl_q.band ? 10'(scss_pkg::B1_PMAX) : 10'(scss_pkg::B0_PMAX);
   wire timeout = (per_q > pmax);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
         per_q <= 10'h000;
         meas_q <= 10'h000;
         fault_live_q <= 1'b1;
      end else begin
         ext_s1_q <= ext_sync_input;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         if (rise) begin
            per_q <= 10'h001;
            meas_q <= per_q;
         end else if (per_q != 10'h3ff) begin
            per_q <= per_q + 10'h001;
         end
         if (timeout) begin
            fault_live_q <= 1'b1;
         end else if (rise) begin
            fault_live_q <= ~in_band(per_q, ctrl_q.band);
         end
      end
   end

   // ==========================================================
   // Source selection and fault event
   scss_pkg::scss_src_t src_q;
   // External path only with PLL running
   wire sync_active = ctrl_q.sync_en & pll_on_q;
   wire fault_set = (src_q == scss_pkg::SRC_EXT) & fault_live_q & sync_active;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         src_q <= scss_pkg::SRC_INT;
         event_q <= 1'b0;
      end else begin
         // Sticky event, set wins over clear
         event_q <= fault_set | (event_q & ~evt_clr);
         unique case (src_q)
            scss_pkg::SRC_INT: begin
               // Return on tick once cleared and valid
               if (lf_tick_q && sync_active && !event_q && !fault_live_q) begin
                  src_q <= scss_pkg::SRC_EXT;
               end
            end
            scss_pkg::SRC_EXT: begin
               if (!sync_active || fault_live_q) begin
                  src_q <= scss_pkg::SRC_INT;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Spread triangle
   logic signed [3:0] tri_q;
   logic up_q;
   logic [10:0] step_q;
   wire spread_on = ctrl_q.spread_en & ~sync_active;
   wire signed [3:0] dev = ctrl_q.width ? 4'(scss_pkg::SS_WIDE_DEV) : 4'(scss_pkg::SS_NARROW_DEV);
   wire signed [3:0] dev_lim = 4'(scss_pkg::SS_WIDE_DEV);
   // Step length sets 24 kHz triangle
   wire [10:0] step_end = ctrl_q.width ? 11'(scss_pkg::SS_WIDE_STEP_CYC - 1) :
                          11'(scss_pkg::SS_NARROW_STEP_CYC - 1);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tri_q <= 4'sh0;
         up_q <= 1'b1;
         step_q <= 11'h000;
      end else if (!spread_on) begin
         tri_q <= 4'sh0;
         up_q <= 1'b1;
         step_q <= 11'h000;
      end else if (step_q >= step_end) begin
         step_q <= 11'h000;
         if (up_q && tri_q >= dev) begin
            up_q <= 1'b0;
            tri_q <= tri_q - 4'sh1;
         end else if (!up_q && tri_q <= -dev) begin
            up_q <= 1'b1;
            tri_q <= tri_q + 4'sh1;
         end else begin
            tri_q <= up_q ? tri_q + 4'sh1 : tri_q - 4'sh1;
         end
      end else begin
         step_q <= step_q + 11'h001;
      end
   end

   // ==========================================================
   // Switching clock generator
   logic [9:0] hc_q;
   logic sw_q, sync_out_q, spread_q, irq_n_q;
   // Tuning only when neither spread nor sync
   wire [9:0] half_int = spread_on ? 10'(scss_pkg::HALF_NOM_CYC) + {{6{tri_q[3]}}, tri_q} :
                         tune_half(ctrl_q.tune);
   wire [9:0] half_ext = ctrl_q.band ? 10'(meas_q / 10'(2 * scss_pkg::PLL_MULT_B1)) :
                         10'(meas_q / 10'(2 * scss_pkg::PLL_MULT_B0));
   wire [9:0] half_sel = (src_q == scss_pkg::SRC_EXT) ? half_ext : half_int;
   wire toggle = (hc_q <= 10'h001);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hc_q <= 10'(scss_pkg::HALF_NOM_CYC);
         sw_q <= 1'b0;
         sync_out_q <= 1'b0;
         spread_q <= 1'b0;
         irq_n_q <= 1'b1;
      end else begin
         if (toggle) begin
            hc_q <= half_sel;
            sw_q <= ~sw_q;
            sync_out_q <= ~sw_q & ctrl_q.out_en;
         end else begin
            hc_q <= hc_q - 10'h001;
         end
         spread_q <= spread_on;
         irq_n_q <= ~(event_q & ~mask_q);
      end
   end

   assign stat = '{pll_on: pll_on_q, spread_on: spread_q,
                   ext_used: (src_q == scss_pkg::SRC_EXT), fault_live: fault_live_q};
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sw_clk_out = sw_q;
   assign sync_output = sync_out_q;
   assign pll_enable = pll_on_q;
   assign ext_source_active = (src_q == scss_pkg::SRC_EXT);
   assign spread_active = spread_q;
   assign irq_out_n = irq_n_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_otp_spread_load: assert property (load_otp |=> ctrl_q.spread_en == $past(otp_s2_q[0]))
      else $error("spread enable default not loaded");
   a_spread_gate: assert property (spread_q |-> $past(ctrl_q.spread_en) && !$past(sync_active))
      else $error("spread active without enable or with sync");
   a_spread_sync_off: assert property (sync_active |=> !spread_q)
      else $error("spread active during external sync");
   a_tri_bound: assert property ((tri_q <= dev_lim) && (tri_q >= -dev_lim))
      else $error("spread deviation beyond wide limit");
   a_pll_off_int: assert property (!pll_on_q |-> src_q == scss_pkg::SRC_INT)
      else $error("external source with PLL off");
   a_band_invalid: assert property (rise && !timeout && !in_band(per_q, ctrl_q.band) |=> fault_live_q)
      else $error("out of band period not flagged");
   a_fault_fallback: assert property (fault_set |=> src_q == scss_pkg::SRC_INT && event_q)
      else $error("no fallback or event on fault");
   a_irq_drive: assert property (event_q && !mask_q |=> !irq_out_n)
      else $error("interrupt not asserted");
   a_return_cond: assert property ($rose(src_q == scss_pkg::SRC_EXT) |-> $past(!event_q && !fault_live_q && lf_tick_q))
      else $error("returned to external too early");
   a_event_sticky: assert property (event_q && !evt_clr |=> event_q)
      else $error("event dropped without clear");
   a_sync_out_phase: assert property ($rose(sync_out_q) |-> sw_q ##1 sync_out_q[*8])
      else $error("sync output pulse truncated");
   a_sync_out_off: assert property (!ctrl_q.out_en && !sync_out_q ##1 !ctrl_q.out_en |-> !sync_out_q)
      else $error("sync output toggles while disabled");
endmodule : scss_top

/* File: tb/scss_sync_src.sv */
// External sync clock source model for the switching clock bench
`timescale 1ns/1ps
module scss_sync_src (
   input wire logic run,
   input wire logic [15:0] half_ns,
   output logic sync_pin
);
   // ==========================================================
   // Clock source
   // Idle low, even duty
   initial begin
      sync_pin = 1'b0;
      forever begin
         wait (run === 1'b1);
         sync_pin = 1'b1;
         #(half_ns);
         sync_pin = 1'b0;
         #(half_ns);
      end
   end
endmodule : scss_sync_src

/* File: tb/testbench.sv */
// Self-checking bench for the switching clock block
`timescale 1ns/1ps
module testbench;
   logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, e, hi;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic ext_sync_input, sw_clk_out, sync_output, pll_enable, ext_source_active, spread_active, irq_out_n;
   logic src_run;
   logic [4:0] otp_v;
   logic [15:0] src_half;
   int err_count, compares, mn, mx;
   // ==========================================================
   // Design and far side
   scss_top dut_u (
      .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_sync_input(ext_sync_input), .otp_spread_enable_default(otp_v[0]), .otp_spread_width_default(otp_v[1]),
      .otp_ext_sync_enable_default(otp_v[2]), .otp_sync_band_default(otp_v[3]), .otp_sync_output_default(otp_v[4]),
      .sw_clk_out(sw_clk_out), .sync_output(sync_output), .pll_enable(pll_enable),
      .ext_source_active(ext_source_active), .spread_active(spread_active), .irq_out_n(irq_out_n)
   );
   scss_sync_src src_u (.run(src_run), .half_ns(src_half), .sync_pin(ext_sync_input));
   // ==========================================================
   // Clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      cyc(80000);
      err_count++;
      results();
   end
   // ==========================================================
   // Tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      e = pslverr;
      chk({31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc
   task automatic phases(input logic sel, input int n, output int lo, output int hi_max);
      int run, k, guard;
      logic v, pv;
      lo = 9999;
      hi_max = 0;
      run = 0;
      k = 0;
      guard = 0;
      pv = 1'b0;
      while (k < n && guard < 20000) begin
         @(posedge clk_sys);
         guard++;
         v = sel ? sync_output : sw_clk_out;
         if (v === 1'b1) begin
            run++;
         end else begin
            if (pv === 1'b1) begin
               if (k > 0 && run < lo) lo = run;
               if (k > 0 && run > hi_max) hi_max = run;
               k++;
            end
            run = 0;
         end
         pv = v;
      end
   endtask : phases
   task automatic results();
      if (err_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   // ==========================================================
   // Tests
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      src_run = 1'b0;
      src_half = 16'd200;
      otp_v = 5'h15;
      err_count = 0;
      compares = 0;
      cyc(12);
      arst_n <= 1'b1;
      cyc(8);
      rdc(8'h00, 32'h15); // strap defaults
      rdc(8'h0c, 32'h0); // mask starts clear
      apb(1'b0, 8'h10, 32'h0);
      chk({e, rd[30:0]}, 32'h80000000);
      chk({30'h0, pll_enable, spread_active}, 32'h2); // PLL on, no spread
      src_run <= 1'b1;
      cyc(4500);
      chk({31'h0, ext_source_active}, 32'h1); // locked in band
      rdc(8'h04, 32'ha); // fault clear
      src_run <= 1'b0;
      cyc(300);
      chk({30'h0, ext_source_active, irq_out_n}, 32'h0); // fallback and interrupt
      rdc(8'h04, 32'h9); // fault live
      src_run <= 1'b1;
      cyc(3000);
      rdc(8'h04, 32'h8); // stays internal
      rdc(8'h08, 32'h1); // event held
      apb(1'b1, 8'h08, 32'h1); // host clears event
      cyc(4500);
      chk({30'h0, ext_source_active, irq_out_n}, 32'h3); // back on external
      src_half <= 16'd50;
      cyc(300);
      chk({30'h0, ext_source_active, irq_out_n}, 32'h0); // fast clock invalid
      apb(1'b1, 8'h0c, 32'h1); // mask interrupt
      apb(1'b1, 8'h08, 32'h1); // clear while invalid
      cyc(4500);
      chk({30'h0, ext_source_active, irq_out_n}, 32'h1); // no return while invalid
      apb(1'b1, 8'h00, 32'h1d); // band select 1
      src_half <= 16'd1250;
      cyc(4500);
      chk({31'h0, ext_source_active}, 32'h1); // low band accepted
      src_run <= 1'b0;
      cyc(1000);
      chk({30'h0, ext_source_active, irq_out_n}, 32'h1); // masked interrupt
      rdc(8'h08, 32'h1); // event held
      apb(1'b1, 8'h0c, 32'h0); // unmask interrupt
      cyc(5);
      chk({31'h0, irq_out_n}, 32'h0); // unmasked interrupt
      apb(1'b1, 8'h08, 32'h1); // clear event
      apb(1'b1, 8'h00, 32'h10); // internal clock only
      cyc(200);
      phases(1'b0, 5, mn, mx);
      chk({mn[15:0], mx[15:0]}, {16'd40, 16'd40}); // divide by eight
      apb(1'b1, 8'h00, 32'h410); // tuned output
      cyc(200);
      phases(1'b1, 5, mn, mx);
      chk({mn[15:0], mx[15:0]}, {16'd33, 16'd33}); // output follows
      apb(1'b1, 8'h00, 32'h411); // spread enable
      cyc(200);
      chk({31'h0, spread_active}, 32'h1); // spread on
      phases(1'b0, 110, mn, mx);
      chk({mn[15:0], mx[15:0]}, {16'd38, 16'd42}); // narrow spread
      apb(1'b1, 8'h00, 32'h413); // wide width
      cyc(200);
      phases(1'b0, 110, mn, mx);
      chk({mn[15:0], mx[15:0]}, {16'd36, 16'd44}); // wide spread
      apb(1'b1, 8'h00, 32'h417); // sync with spread
      cyc(5);
      chk({31'h0, spread_active}, 32'h0); // sync overrides spread
      apb(1'b1, 8'h00, 32'h402); // output disabled
      cyc(60);
      hi = 1'b0;
      repeat (200) begin
         @(posedge clk_sys);
         hi = hi | sync_output;
      end
      chk({30'h0, hi, spread_active}, 32'h0); // output low, spread off
      // ==========================================================
      // Second power-up with other strap values
      arst_n <= 1'b0;
      otp_v <= 5'h0a;
      cyc(3);
      chk({29'h0, irq_out_n, sw_clk_out, ext_source_active}, 32'h4); // idle outputs in reset
      arst_n <= 1'b1;
      cyc(8);
      rdc(8'h00, 32'h0a); // strap defaults
      chk({31'h0, pll_enable}, 32'h0); // PLL off
      apb(1'b1, 8'h00, 32'h0e); // sync requested
      src_run <= 1'b1;
      cyc(4500);
      rdc(8'h04, 32'h0); // internal, input valid
      chk({31'h0, ext_source_active}, 32'h0); // never external
      results();
   end
endmodule : testbench
